//--- bench/irq_trap_tb.sv
// Register-level test of the polarity, vector and power-fail trap block.
// Assumes a 40 MHz clock and the one-cycle register port of the design.
`timescale 1ns/10ps
`include "irq_trap_consts.svh"
module irq_trap_tb;
    import irq_trap_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wdt_rst = 1'b0;
    logic clk_en = 1'b1;
    reg_req_t req = '0;
    logic [15:0] src_level = 16'h0000;
    logic pf_drop = 1'b0;
    logic [15:0] channel_src;
    logic pf_n;
    logic [7:0] rdata;
    logic trap_n;
    logic irq;
    integer fail_count = 0;
    integer checks = 0;

    always #12.5 clk = ~clk;

    src_model u_src (.clk_in(clk), .level_in(src_level),
        .pf_drop_in(pf_drop), .channel_src_out(channel_src),
        .power_fail_n_out(pf_n));

    irq_trap u_dut (.clk_sys_in(clk), .rst_in(rst), .wdt_rst_in(wdt_rst),
        .clk_en_in(clk_en), .req_in(req), .channel_src_in(channel_src),
        .power_fail_input_n_in(pf_n), .rdata_out(rdata),
        .cpu_trap_line_n_out(trap_n), .irq_out(irq));

    ////////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        @(negedge clk);
        chk8(rdata, exp);
        @(posedge clk);
    endtask

    // Pins are compared mid-cycle; exp is {trap line, irq}.
    task automatic chk_pins(input logic [1:0] exp);
        @(negedge clk);
        chk8({6'h00, trap_n, irq}, {6'h00, exp});
        @(posedge clk);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        #100000;
        fail_count++;
        conclude();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_chk(`OFS_POL_A, 8'h00);
        rd_chk(`OFS_VECTOR, 8'h10);
        rd_chk(`OFS_PF_CONTROL, 8'h02);
        rd_chk(`OFS_TRAP_STATUS, 8'h00);
        rd_chk(8'h20, 8'h00);
        chk_pins(2'b10);
        wr(`OFS_POL_B, 8'hA5);
        rd_chk(`OFS_POL_B, 8'hA5);
        // Two level channels pending: the higher number wins.
        wr(`OFS_CH_ENABLE, 8'h22);
        src_level <= 16'h0022;
        idle(4);
        rd_chk(`OFS_VECTOR, 8'h25);
        wr(`OFS_POL_A, 8'h20);
        idle(4);
        rd_chk(`OFS_VECTOR, 8'h21);
        wr(`OFS_CH_ENABLE, 8'h00);
        idle(4);
        rd_chk(`OFS_VECTOR, 8'h10);
        // Channel 16 is edge mode: a pulse stays pending after it ends.
        wr(`OFS_CH_ENABLE, 8'h01);
        src_level <= 16'h0001;
        idle(2);
        src_level <= 16'h0000;
        idle(4);
        rd_chk(`OFS_VECTOR, 8'h20);
        wr(`OFS_CH_ENABLE, 8'h00);
        wr(`OFS_IRQ_MASK, 8'h00);
        idle(2);
        chk_pins(2'b10);
        wr(`OFS_IRQ_MASK, 8'h03);
        idle(2);
        chk_pins(2'b11);
        wr(`OFS_IRQ_STATUS, 8'h03);
        rd_chk(`OFS_IRQ_STATUS, 8'h00);
        chk_pins(2'b10);
        // A write while the clock enable is low must not land.
        clk_en <= 1'b0;
        wr(`OFS_POL_A, 8'hFF);
        clk_en <= 1'b1;
        rd_chk(`OFS_POL_A, 8'h20);
        // One-shot arm: fires once, then disarms itself.
        wr(`OFS_PF_CONTROL, 8'h01);
        pf_drop <= 1'b1;
        idle(8);
        chk_pins(2'b01);
        rd_chk(`OFS_PF_CONTROL, 8'h00);
        rd_chk(`OFS_TRAP_STATUS, 8'h01);
        chk_pins(2'b11);
        rd_chk(`OFS_TRAP_STATUS, 8'h00);
        pf_drop <= 1'b0;
        idle(8);
        pf_drop <= 1'b1;
        idle(8);
        rd_chk(`OFS_TRAP_STATUS, 8'h00);
        pf_drop <= 1'b0;
        idle(8);
        // Locked arm survives a written zero, a trap and a watchdog reset.
        wr(`OFS_PF_CONTROL, 8'h04);
        wr(`OFS_PF_CONTROL, 8'h00);
        rd_chk(`OFS_PF_CONTROL, 8'h06);
        pf_drop <= 1'b1;
        idle(8);
        rd_chk(`OFS_TRAP_STATUS, 8'h01);
        rd_chk(`OFS_PF_CONTROL, 8'h04);
        pf_drop <= 1'b0;
        idle(8);
        wdt_rst <= 1'b1;
        idle(1);
        wdt_rst <= 1'b0;
        rd_chk(`OFS_PF_CONTROL, 8'h06);
        rst <= 1'b1;
        idle(1);
        rst <= 1'b0;
        rd_chk(`OFS_PF_CONTROL, 8'h02);
        conclude();
    end
endmodule

//--- bench/src_model.sv
// Behavioural model of the interrupt sources and the power-fail supervisor.
// Assumes the bench asks for levels; power fail moves off the clock edge.
`timescale 1ns/10ps
module src_model
(
    input wire logic clk_in,
    input wire logic [15:0] level_in,
    input wire logic pf_drop_in,
    output logic [15:0] channel_src_out,
    output logic power_fail_n_out
);
    initial channel_src_out = 16'h0000;
    initial power_fail_n_out = 1'b1;
    // Power fail is asynchronous, so it lands well away from the edge.
    always @(posedge clk_in)
    begin
        channel_src_out <= level_in;
        power_fail_n_out <= #7 ~pf_drop_in;
    end
endmodule

//--- verilog/irq_trap.sv
// Polarity select for channels 16 to 31, fixed-priority vector and the
// power-fail trap that drives the core's trap line.
// Assumes channel sources are on clk_sys_in; power fail is asynchronous.
`timescale 1ns/10ps
`include "irq_trap_consts.svh"

////////////////////////////////////////////////////////////////////////
module irq_trap
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic wdt_rst_in,
    input wire logic clk_en_in,
    input wire irq_trap_pkg::reg_req_t req_in,
    input wire logic [15:0] channel_src_in,
    input wire logic power_fail_input_n_in,
    output logic [7:0] rdata_out,
    output logic cpu_trap_line_n_out,
    output logic irq_out
);
    import irq_trap_pkg::*;

    state_t s_reg;
    state_t s_next;
    logic [15:0] active;
    logic [15:0] hits;
    logic pf_fall;
    logic pf_armed;
    logic [5:0] vec_calc;
    logic ev_vec;

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_next = s_reg;
        pf_fall = s_reg.pf_prev & ~s_reg.pf_sync[1];
        pf_armed = s_reg.locked | s_reg.oneshot;
        active = channel_src_in ^ s_reg.pol;
        for (int i = 0; i < 16; i++)
        begin
            if (s_reg.mode[i])
                s_next.pend[i] = s_reg.pend[i] | (active[i] & ~s_reg.prev[i]);
            else
                s_next.pend[i] = active[i];
        end
        s_next.prev = active;
        hits = s_reg.pend & s_reg.en;
        vec_calc = `VEC_BASE;
        for (int i = 0; i < 16; i++)
        begin
            if (hits[i])
                vec_calc = `VEC_BASE + 6'(16 + i);
        end
        s_next.vector = vec_calc;
        ev_vec = (hits != 16'h0000);
        s_next.pf_sync = {s_reg.pf_sync[0], power_fail_input_n_in};
        s_next.pf_prev = s_reg.pf_sync[1];
        s_next.rdata = 8'h00;
        if (req_in.rd)
        begin
            case (req_in.addr)
                `OFS_POL_A: s_next.rdata = s_reg.pol[7:0];
                `OFS_POL_B: s_next.rdata = s_reg.pol[15:8];
                `OFS_VECTOR: s_next.rdata = {2'b00, s_reg.vector};
                `OFS_TRAP_STATUS: s_next.rdata = {7'h00, s_reg.trap};
                `OFS_PF_CONTROL: s_next.rdata = {5'h00, s_reg.locked,
                    s_reg.pf_sync[1], s_reg.oneshot};
                `OFS_IRQ_STATUS: s_next.rdata = {6'h00, s_reg.irq_stat};
                `OFS_IRQ_MASK: s_next.rdata = {6'h00, s_reg.irq_mask};
                `OFS_CH_ENABLE: s_next.rdata = s_reg.en[7:0];
                `OFS_CH_MODE: s_next.rdata = s_reg.mode[7:0];
                default: s_next.rdata = 8'h00;
            endcase
        end
        if (req_in.rd && req_in.addr == `OFS_TRAP_STATUS)
            s_next.trap = 1'b0;
        if (req_in.wr)
        begin
            case (req_in.addr)
                `OFS_POL_A: s_next.pol[7:0] = req_in.wdata;
                `OFS_POL_B: s_next.pol[15:8] = req_in.wdata;
                `OFS_PF_CONTROL:
                begin
                    s_next.oneshot = req_in.wdata[`BIT_ONESHOT];
                    s_next.locked = s_reg.locked |
                        req_in.wdata[`BIT_LOCKED];
                end
                `OFS_IRQ_STATUS: s_next.irq_stat =
                    s_reg.irq_stat & ~req_in.wdata[1:0];
                `OFS_IRQ_MASK: s_next.irq_mask = req_in.wdata[1:0];
                `OFS_CH_ENABLE: s_next.en[7:0] = req_in.wdata;
                `OFS_CH_MODE: s_next.mode[7:0] = req_in.wdata;
                default: s_next.rdata = s_next.rdata;
            endcase
        end
        // Armed falling edge sets trap; set wins over read clear.
        if (pf_fall && pf_armed)
        begin
            s_next.trap = 1'b1;
            if (!s_reg.locked)
                s_next.oneshot = 1'b0;
        end
        if (pf_fall && pf_armed)
            s_next.irq_stat[`EV_TRAP] = 1'b1;
        if (ev_vec)
            s_next.irq_stat[`EV_VECTOR] = 1'b1;
        s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
        // Trap line is its own flop.
        s_next.trap_line_n = ~s_next.trap;
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            s_reg <= '0;
            s_reg.pol <= {`RST_POL, `RST_POL};
            s_reg.mode <= `RST_MODE;
            s_reg.vector <= `VEC_BASE;
            s_reg.pf_sync <= 2'b11;
            s_reg.pf_prev <= 1'b1;
            s_reg.trap_line_n <= 1'b1;
        end
        else if (wdt_rst_in)
        begin
            s_reg <= '0;
            s_reg.oneshot <= s_reg.oneshot;
            s_reg.locked <= s_reg.locked;
            s_reg.pol <= {`RST_POL, `RST_POL};
            s_reg.mode <= `RST_MODE;
            s_reg.vector <= `VEC_BASE;
            s_reg.pf_sync <= 2'b11;
            s_reg.pf_prev <= 1'b1;
            s_reg.trap_line_n <= 1'b1;
        end
        else if (clk_en_in)
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Trap line follows status.
    assign cpu_trap_line_n_out = s_reg.trap_line_n;
    assign rdata_out = s_reg.rdata;
    assign irq_out = s_reg.irq;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in || wdt_rst_in || !clk_en_in);

    property p_trap_set;
        pf_fall && pf_armed |=> s_reg.trap;
    endproperty
    a_trap_set: assert property (p_trap_set)
        else $error("Trap not set on armed power fail edge");

    property p_trap_unarmed;
        !pf_armed && !s_reg.trap |=> !s_reg.trap;
    endproperty
    a_trap_unarmed: assert property (p_trap_unarmed)
        else $error("Trap set while unarmed");

    property p_read_clear;
        req_in.rd && req_in.addr == `OFS_TRAP_STATUS && !pf_fall
            |=> !s_reg.trap;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("Trap status not cleared by read");

    property p_line;
        cpu_trap_line_n_out == !s_reg.trap;
    endproperty
    a_line: assert property (p_line)
        else $error("Trap line disagrees with status");

    property p_locked_sticky;
        s_reg.locked |=> s_reg.locked;
    endproperty
    a_locked_sticky: assert property (p_locked_sticky)
        else $error("Locked enable cleared");

    property p_oneshot_clear;
        pf_fall && s_reg.oneshot && !s_reg.locked |=> !s_reg.oneshot;
    endproperty
    a_oneshot_clear: assert property (p_oneshot_clear)
        else $error("One-shot enable not cleared");

    property p_vec_range;
        s_reg.vector >= 6'h10 && s_reg.vector <= 6'h2F;
    endproperty
    a_vec_range: assert property (p_vec_range)
        else $error("Vector out of range");

    property p_vec_idle;
        (s_reg.pend & s_reg.en) == 16'h0000 |=> s_reg.vector == 6'h10;
    endproperty
    a_vec_idle: assert property (p_vec_idle)
        else $error("Idle vector is not base");

    property p_vec_top;
        s_reg.pend[15] && s_reg.en[15] |=> s_reg.vector == 6'h2F;
    endproperty
    a_vec_top: assert property (p_vec_top)
        else $error("Top channel did not win");

    property p_vec_read;
        req_in.rd && req_in.addr == `OFS_VECTOR
            |=> rdata_out[7:6] == 2'b00;
    endproperty
    a_vec_read: assert property (p_vec_read)
        else $error("Vector upper bits not zero");

    property p_pf_level;
        req_in.rd && req_in.addr == `OFS_PF_CONTROL
            |=> rdata_out[1] == $past(s_reg.pf_sync[1]);
    endproperty
    a_pf_level: assert property (p_pf_level)
        else $error("Power fail level bit wrong");

    property p_locked_fires;
        s_reg.locked && pf_fall |=> s_reg.trap;
    endproperty
    a_locked_fires: assert property (p_locked_fires)
        else $error("Locked enable did not trap");

    c_trap: cover property (pf_fall && pf_armed);
    c_locked: cover property (s_reg.locked && pf_fall);
    c_vector: cover property (s_reg.vector == 6'h2F);
    c_irq: cover property (irq_out);
endmodule

//--- verilog/irq_trap_consts.svh
// Register offsets, field positions and reset values of the polarity,
// vector and power-fail trap block.
// Assumes an 8-bit register port with byte offsets.
`ifndef IRQ_TRAP_CONSTS_SVH
`define IRQ_TRAP_CONSTS_SVH
`define OFS_POL_A 8'h0E
`define OFS_POL_B 8'h0F
`define OFS_VECTOR 8'h10
`define OFS_TRAP_STATUS 8'h11
`define OFS_PF_CONTROL 8'h12
`define OFS_IRQ_STATUS 8'h13
`define OFS_IRQ_MASK 8'h14
`define OFS_CH_ENABLE 8'h15
`define OFS_CH_MODE 8'h16
`define BIT_ONESHOT 0
`define BIT_PF_LEVEL 1
`define BIT_LOCKED 2
`define BIT_TRAP 0
`define VEC_BASE 6'h10
`define RST_POL 8'h00
`define RST_VECTOR 8'h10
`define RST_MODE 16'h4C1D
`define EV_TRAP 0
`define EV_VECTOR 1
`endif

//--- verilog/irq_trap_pkg.sv
// Types of the polarity, vector and power-fail trap block.
// Assumes the constants header is included by users as well.
package irq_trap_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef enum logic [1:0] {
        PF_IDLE = 2'b00,
        PF_ARMED = 2'b01,
        PF_LOCKED = 2'b10
    } pf_mode_t;
    typedef struct packed {
        logic [15:0] pol;
        logic [15:0] en;
        logic [15:0] mode;
        logic [15:0] prev;
        logic [15:0] pend;
        logic [1:0] pf_sync;
        logic pf_prev;
        logic trap;
        logic oneshot;
        logic locked;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [5:0] vector;
        logic [7:0] rdata;
        logic irq;
        logic trap_line_n;
    } state_t;
endpackage
